// ---- dv/core_model.sv ----
// core pipeline stand-in that issues lookups and gathers the answers
`timescale 1ns/1ps
module core_model (
   input wire logic clk,
   output logic req_valid,
   output tlb_pkg::acc_e req_kind,
   output logic req_io,
   output logic [31:0] req_virtual_address,
   input wire logic resp_valid,
   input wire logic [31:0] resp_paddr,
   input wire logic resp_cacheable,
   input wire logic resp_bus_ok,
   input wire logic resp_perm_fault,
   input wire logic resp_fast_miss,
   input wire logic resp_double_miss
);
   // idle request lines at time zero
   initial
   begin
      req_valid = 1'b0;
      req_kind = tlb_pkg::ACC_FETCH;
      req_io = 1'b0;
      req_virtual_address = 32'h0;
   end
   // one lookup after some idle cycles; lines scramble once released
   task automatic lookup(input int idle, input tlb_pkg::acc_e k, input logic io,
      input logic [31:0] va, output logic [37:0] res);
      int n;
      repeat (idle) @(posedge clk);
      @(posedge clk);
      req_valid <= 1'b1;
      req_kind <= k;
      req_io <= io;
      req_virtual_address <= va;
      @(posedge clk);
      req_valid <= 1'b0;
      req_io <= ~io;
      req_virtual_address <= ~va;
      n = 0;
      while (resp_valid !== 1'b1 && n < 6)
      begin
         @(posedge clk);
         n++;
      end
      // address and cacheability only mean something when the bus is allowed
      res = {resp_valid, resp_bus_ok ? resp_paddr : 32'h0, resp_cacheable & resp_bus_ok,
         resp_bus_ok, resp_perm_fault, resp_fast_miss, resp_double_miss};
   endtask
endmodule

// ---- dv/shared_translation_lookaside_buffer_tb.sv ----
// self-checking bench for the shared translation buffer
`timescale 1ns/1ps
`include "tlb_defs.svh"
module shared_translation_lookaside_buffer_tb;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, r;
   logic req_valid, req_io, resp_valid, resp_cacheable, resp_bus_ok;
   logic resp_perm_fault, resp_fast_miss, resp_double_miss;
   tlb_pkg::acc_e req_kind;
   logic [31:0] req_virtual_address, resp_paddr;
   logic [20:0] m_tag [128];
   logic [27:0] m_dat [128];
   logic [7:0] m_pid [128];
   logic [19:0] vpn_q [12];
   logic [7:0] cur_pid;
   logic cur_eh;
   int n_fail, samples_checked, seed;

   shared_tlb i_shared_tlb (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .req_valid, .req_kind, .req_io, .req_virtual_address,
      .resp_valid, .resp_paddr, .resp_cacheable, .resp_bus_ok, .resp_perm_fault,
      .resp_fast_miss, .resp_double_miss);
   core_model i_core_model (.clk, .req_valid, .req_kind, .req_io, .req_virtual_address,
      .resp_valid, .resp_paddr, .resp_cacheable, .resp_bus_ok, .resp_perm_fault,
      .resp_fast_miss, .resp_double_miss);

   // 125 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_lk(input string nm, input logic [37:0] e, input logic [37:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer, held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k == 20)
         n_fail++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // load one whole entry and mirror it
   task automatic put(input logic [19:0] virtual_page_number, input logic [3:0] way, input logic g,
      input logic [27:0] dat, input logic [7:0] process_tag);
      int j;
      j = {virtual_page_number[2:0], way};
      apb(1'b1, `TLB_OFS_TAG, {g, 11'h0, virtual_page_number});
      apb(1'b1, `TLB_OFS_DATA, {4'h0, dat});
      apb(1'b1, `TLB_OFS_COMMIT, {8'h0, process_tag, 12'h0, way});
      m_tag[j] = {g, virtual_page_number};
      m_dat[j] = dat;
      m_pid[j] = process_tag;
   endtask

   // expected answer: {valid, paddr, cacheable, bus_ok, perm, fast, double}
   function automatic logic [37:0] exp_lk(input tlb_pkg::acc_e k, input logic io,
      input logic [31:0] va);
      logic hit;
      logic ok;
      logic [27:0] d;
      hit = 1'b0;
      d = 28'h0;
      if (va[31:30] == 2'b11)
         return {1'b1, 3'h0, va[28:0], (va[31:29] == 3'b110) && !io, 4'b1000};
      for (int j = 0; j < 128; j++)
         if (m_tag[j][19:0] == va[31:12] && (m_tag[j][20] || m_pid[j] == cur_pid))
         begin
            hit = 1'b1;
            d = m_dat[j];
         end
      if (!hit)
         return {1'b1, 32'h0, 3'h0, !cur_eh, cur_eh};
      case (k)
         tlb_pkg::ACC_FETCH: ok = d[27];
         tlb_pkg::ACC_LOAD: ok = d[25];
         tlb_pkg::ACC_STORE: ok = d[26];
         default: ok = 1'b1;
      endcase
      if (!ok)
         return {1'b1, 32'h0, 5'b00100};
      return {1'b1, d[19:0], va[11:0], d[24] && !io, 4'b1000};
   endfunction

   task automatic look(input tlb_pkg::acc_e k, input logic io, input logic [31:0] va);
      logic [37:0] res;
      i_core_model.lookup($unsigned($random(seed)) % 3, k, io, va, res);
      chk_lk("lookup", exp_lk(k, io, va), res);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // main sequence
   initial
   begin
      seed = 95;
      n_fail = 0;
      samples_checked = 0;
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      cur_pid = 8'h0;
      cur_eh = 1'b0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // reset values, ignored status write, unmapped address
      apb(1'b1, `TLB_OFS_STATUS, 32'hFFFF_FFFF);
      for (int a = 0; a < 5; a++)
      begin
         apb(1'b0, 8'(a * 4), 32'hA5A5_A5A5);
         chk_reg("reset value", 32'h0, rd);
      end
      apb(1'b0, 8'h14, 32'h0);
      chk_reg("unmapped error", 32'h1, {31'h0, er});
      // invalidate every slot with distinct io-partition pages
      for (int w = 0; w < 16; w++)
         for (int s = 0; s < 8; s++)
            put(20'hE0000 | {13'h0, w[3:0], s[2:0]}, w[3:0], 1'b0, 28'h0, 8'h0);
      // random entries, distinct pages below the bypass range, any way
      for (int i = 0; i < 12; i++)
      begin
         r = $random(seed);
         vpn_q[i] = {1'b0, r[30:16], i[3:0]};
         put(vpn_q[i], r[3:0], r[4], {r[11:8], 4'h0, r[31:12]}, r[5] ? 8'h5A : 8'h00);
         apb(1'b0, `TLB_OFS_TAG, 32'h0);
         chk_reg("tag readback", {r[4], 11'h0, vpn_q[i]}, rd);
         apb(1'b0, `TLB_OFS_COMMIT, 32'h0);
         chk_reg("way readback", {28'h0, r[3:0]}, rd);
      end
      // every kind on every entry under both handler states and process ids
      for (int ph = 0; ph < 4; ph++)
      begin
         cur_eh = ph[0];
         cur_pid = ph[1] ? 8'h5A : 8'h00;
         apb(1'b1, `TLB_OFS_CTRL, {cur_eh, 23'h0, cur_pid});
         for (int i = 0; i < 12; i++)
         begin
            r = $random(seed);
            look(tlb_pkg::acc_e'(2'(i + ph)), r[0],
               {vpn_q[i], r[15:4]});
            look(tlb_pkg::acc_e'(r[2:1]), r[3], {vpn_q[i] ^ 20'h10, r[27:16]});
            // the miss just seen is the latest fault on record
            apb(1'b0, `TLB_OFS_STATUS, 32'h0);
            chk_reg("fault record", {2'h0, r[2:1], 1'b0, cur_eh, !cur_eh, 5'h0,
               vpn_q[i] ^ 20'h10}, rd);
         end
         look(tlb_pkg::ACC_LOAD, r[0], {3'b110, r[28:0]});
         look(tlb_pkg::ACC_STORE, r[1], {3'b111, r[28:0]});
      end
      final_report();
   end

   // watchdog: about 2500 cycles expected, cut off at 50000
   initial
   begin
      #400000;
      n_fail++;
      final_report();
   end
endmodule

// ---- hdl/shared_tlb.sv ----
// translation lookaside buffer shared by fetch and data accesses, apb control
//
// Operation
// - one buffer translates fetches and data accesses
// - entries live in block ram
// - set associative, software picks the way
// - entry and way counts are parameters
// - default entry count 128
// - tag page compared with top 20 bits
// - tag process id matches current process id
// - global entries ignore process id
// - frame field up to 20 bits
// - physical address is frame plus offset
// - cacheable flag, io accesses always uncached
// - loads need read permission
// - stores need write permission
// - fetches need execute permission
// - line flush ignores read and write permission
// - miss gives double or fast miss
// - top partitions bypass, clear top three bits
`timescale 1ns/1ps
`include "tlb_defs.svh"
module shared_tlb #(
   parameter int ENTRIES = 128,
   parameter int WAYS = 16,
   parameter int PID_W = 8,
   parameter int PFN_W = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   input wire tlb_pkg::acc_e req_kind,
   input wire logic req_io,
   input wire logic [31:0] req_virtual_address,
   output logic resp_valid,
   output logic [31:0] resp_paddr,
   output logic resp_cacheable,
   output logic resp_bus_ok,
   output logic resp_perm_fault,
   output logic resp_fast_miss,
   output logic resp_double_miss
);

   localparam int SETS = ENTRIES / WAYS;
   localparam int SET_W = (SETS > 1) ? $clog2(SETS) : 1;
   localparam int WAY_W = (WAYS > 1) ? $clog2(WAYS) : 1;
   // entry: {page, process id, global, frame, c, r, w, x}
   localparam int EW = `TLB_VPN_W + PID_W + 1 + PFN_W + 4;
   localparam int X_POS = 0;
   localparam int W_POS = 1;
   localparam int R_POS = 2;
   localparam int C_POS = 3;
   localparam int PFN_LSB = 4;
   localparam int G_POS = PFN_LSB + PFN_W;
   localparam int PID_LSB = G_POS + 1;
   localparam int VPN_LSB = PID_LSB + PID_W;
   // software visible state
   logic [PID_W-1:0] cur_pid_r;
   logic [31:0] tag_r, data_r, status_r;
   logic [WAY_W-1:0] last_way_r;
   logic eh_r, pready_r;
   // apb decode
   logic acc_phase, wr_fire, rd_fire, addr_ok;
   logic [31:0] rd_mux;
   assign acc_phase = psel && penable;
   assign wr_fire = acc_phase && pready_r && pwrite;
   assign rd_fire = acc_phase && !pready_r;
   assign addr_ok = (paddr == `TLB_OFS_CTRL) || (paddr == `TLB_OFS_TAG) ||
                    (paddr == `TLB_OFS_DATA) || (paddr == `TLB_OFS_COMMIT) ||
                    (paddr == `TLB_OFS_STATUS);

   // read data selection, unmapped reads as zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `TLB_OFS_CTRL:
         begin
            rd_mux[PID_W-1:0] = cur_pid_r;
            rd_mux[`TLB_CTRL_EH_BIT] = eh_r;
         end
         `TLB_OFS_TAG: rd_mux = tag_r;
         `TLB_OFS_DATA: rd_mux = data_r;
         `TLB_OFS_COMMIT: rd_mux[WAY_W-1:0] = last_way_r;
         `TLB_OFS_STATUS: rd_mux = status_r;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // one wait state, answer registered
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pready_r <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready_r <= rd_fire;
         if (rd_fire)
         begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !addr_ok;
         end
         else
            pslverr <= 1'b0;
      end
   end
   assign pready = pready_r;
   // control and entry staging registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cur_pid_r <= PID_W'(`TLB_RST_CTRL);
         eh_r <= 1'b0;
         tag_r <= `TLB_RST_TAG;
         data_r <= `TLB_RST_DATA;
      end
      else if (wr_fire)
      begin
         if (paddr == `TLB_OFS_CTRL)
         begin
            cur_pid_r <= pwdata[PID_W-1:0];
            eh_r <= pwdata[`TLB_CTRL_EH_BIT];
         end
         if (paddr == `TLB_OFS_TAG)
            tag_r <= pwdata;
         if (paddr == `TLB_OFS_DATA)
            data_r <= pwdata;
      end
   end
   // commit assembles the whole entry at once
   logic ram_we;
   logic [EW-1:0] ram_wdata;
   logic [WAY_W-1:0] ram_wway;
   assign ram_we = wr_fire && (paddr == `TLB_OFS_COMMIT);
   // way comes from the commit write
   assign ram_wway = pwdata[WAY_W-1:0];
   assign ram_wdata = {tag_r[`TLB_VPN_W-1:0], pwdata[16 +: PID_W],
                       tag_r[`TLB_TAG_G_BIT], data_r[PFN_W-1:0],
                       data_r[`TLB_DATA_C_BIT], data_r[`TLB_DATA_R_BIT],
                       data_r[`TLB_DATA_W_BIT], data_r[`TLB_DATA_X_BIT]};
   // last way written, for readback
   always_ff @(posedge clk)
   begin
      if (rst)
         last_way_r <= '0;
      else if (ram_we)
         last_way_r <= ram_wway;
   end
   // entries held in the ram block
   logic [WAYS*EW-1:0] set_rdata;
   tlb_way_ram #(
      .SETS(SETS),
      .WAYS(WAYS),
      .EW(EW),
      .SET_W(SET_W),
      .WAY_W(WAY_W)
   ) u_ram (
      .clk(clk),
      .we(ram_we),
      .wset(tag_r[SET_W-1:0]),
      .wway(ram_wway),
      .wdata(ram_wdata),
      .rset(req_virtual_address[`TLB_OFF_W +: SET_W]),
      .rdata(set_rdata)
   );

   // lookup stage one: request captured while the set is read
   logic s1_valid_r, s1_io_r, s1_eh_r;
   tlb_pkg::acc_e s1_kind_r;
   logic [PID_W-1:0] s1_pid_r;
   logic [31:0] s1_va_r;
   // single request path for every kind
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s1_valid_r <= 1'b0;
         s1_kind_r <= tlb_pkg::ACC_FETCH;
         s1_io_r <= 1'b0;
         s1_eh_r <= 1'b0;
         s1_pid_r <= '0;
         s1_va_r <= 32'h0000_0000;
      end
      else
      begin
         s1_valid_r <= req_valid;
         s1_kind_r <= req_kind;
         s1_io_r <= req_io;
         s1_eh_r <= eh_r;
         s1_pid_r <= cur_pid_r;
         s1_va_r <= req_virtual_address;
      end
   end

   // per way match, masked entry for the or-select
   logic [WAYS-1:0] way_hit;
   logic [EW-1:0] way_sel [WAYS];
   genvar w;
   generate
      for (w = 0; w < WAYS; w++)
      begin : g_cmp
         logic [EW-1:0] ent;
         assign ent = set_rdata[w*EW +: EW];
         assign way_hit[w] = (ent[VPN_LSB +: `TLB_VPN_W] == s1_va_r[31:`TLB_OFF_W]) &&
                             (ent[G_POS] || (ent[PID_LSB +: PID_W] == s1_pid_r));
         assign way_sel[w] = way_hit[w] ? ent : '0;
      end
   endgenerate

   // several hits are undefined, entries simply or together
   logic [EW-1:0] hit_ent;
   always_comb
   begin
      hit_ent = '0;
      for (int i = 0; i < WAYS; i++)
         hit_ent = hit_ent | way_sel[i];
   end
   // translation decision
   logic bypass, hit, allowed, cache_nxt;
   logic [31:0] pa_nxt;
   // top partitions never use the entries
   assign bypass = (s1_va_r[31:30] == `TLB_BYPASS_TOP);
   assign hit = |way_hit;
   // permission flag picked by access kind
   always_comb
   begin
      allowed = 1'b0;
      case (s1_kind_r)
         tlb_pkg::ACC_FETCH: allowed = hit_ent[X_POS];
         tlb_pkg::ACC_LOAD: allowed = hit_ent[R_POS];
         tlb_pkg::ACC_STORE: allowed = hit_ent[W_POS];
         tlb_pkg::ACC_FLUSH: allowed = 1'b1;
         default: allowed = 1'b0;
      endcase
   end
   // physical address and cacheability
   always_comb
   begin
      pa_nxt = 32'h0000_0000;
      cache_nxt = 1'b0;
      if (bypass)
      begin
         pa_nxt[28:0] = s1_va_r[28:0];
         cache_nxt = (s1_va_r[31:29] == `TLB_KERNEL_PART);
      end
      else
      begin
         pa_nxt[PFN_W+`TLB_OFF_W-1:0] = {hit_ent[PFN_LSB +: PFN_W],
                                          s1_va_r[`TLB_OFF_W-1:0]};
         cache_nxt = hit_ent[C_POS];
      end
      if (s1_io_r)
         cache_nxt = 1'b0;
   end
   // stage two: registered answer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         resp_valid <= 1'b0;
         resp_paddr <= 32'h0000_0000;
         resp_cacheable <= 1'b0;
         resp_bus_ok <= 1'b0;
         resp_perm_fault <= 1'b0;
         resp_fast_miss <= 1'b0;
         resp_double_miss <= 1'b0;
      end
      else
      begin
         resp_valid <= s1_valid_r;
         resp_paddr <= pa_nxt;
         resp_cacheable <= s1_valid_r && cache_nxt;
         // no bus cycle on any fault
         resp_bus_ok <= s1_valid_r && (bypass || (hit && allowed));
         resp_perm_fault <= s1_valid_r && !bypass && hit && !allowed;
         // handler flag picks the miss kind
         resp_fast_miss <= s1_valid_r && !bypass && !hit && !s1_eh_r;
         resp_double_miss <= s1_valid_r && !bypass && !hit && s1_eh_r;
      end
   end
   // last fault record for software
   always_ff @(posedge clk)
   begin
      if (rst)
         status_r <= `TLB_RST_STATUS;
      else if (s1_valid_r && !bypass && !(hit && allowed))
      begin
         status_r <= 32'h0000_0000;
         status_r[`TLB_VPN_W-1:0] <= s1_va_r[31:`TLB_OFF_W];
         status_r[`TLB_STAT_PERM_BIT] <= hit;
         status_r[`TLB_STAT_FAST_BIT] <= !hit && !s1_eh_r;
         status_r[`TLB_STAT_DBL_BIT] <= !hit && s1_eh_r;
         status_r[`TLB_STAT_KIND_LSB +: 2] <= s1_kind_r;
      end
   end
   // offset kept one more stage for checking
   logic [`TLB_OFF_W-1:0] off_s2_r;
   always_ff @(posedge clk)
   begin
      off_s2_r <= s1_va_r[`TLB_OFF_W-1:0];
   end
   a_resp_latency: assert property (@(posedge clk) disable iff (rst)
      req_valid |-> ##2 resp_valid)
      else $error("lookup answer not two cycles after request");
   a_double_miss: assert property (@(posedge clk) disable iff (rst)
      resp_double_miss |-> $past(eh_r, 2) && !resp_fast_miss)
      else $error("double miss without handler flag");
   a_fast_miss: assert property (@(posedge clk) disable iff (rst)
      resp_fast_miss |-> !$past(eh_r, 2))
      else $error("fast miss while handler flag set");
   a_fault_no_bus: assert property (@(posedge clk) disable iff (rst)
      (resp_perm_fault || resp_fast_miss || resp_double_miss) |-> !resp_bus_ok)
      else $error("faulting access allowed onto the bus");
   a_bypass_ok: assert property (@(posedge clk) disable iff (rst)
      (req_valid && req_virtual_address[31:30] == 2'h3) |-> ##2
      (resp_bus_ok && !resp_fast_miss && !resp_double_miss && resp_paddr[31:29] == 3'h0))
      else $error("bypass access translated or missed");
   a_io_uncached: assert property (@(posedge clk) disable iff (rst)
      (req_valid && req_io) |-> ##2 !resp_cacheable)
      else $error("io access marked cacheable");
   a_flush_perm: assert property (@(posedge clk) disable iff (rst)
      (req_valid && req_kind == tlb_pkg::ACC_FLUSH) |-> ##2 !resp_perm_fault)
      else $error("flush raised permission fault");
   a_page_offset: assert property (@(posedge clk) disable iff (rst)
      resp_bus_ok |-> resp_paddr[11:0] == off_s2_r)
      else $error("page offset altered");
   a_apb_wait: assert property (@(posedge clk) disable iff (rst)
      (psel && penable && !pready) |=> pready)
      else $error("apb access not answered after one wait");

endmodule

// ---- hdl/tlb_defs.svh ----
// register offsets, field positions and reset values of the translation buffer
`ifndef TLB_DEFS_SVH
`define TLB_DEFS_SVH

`define TLB_OFS_CTRL 8'h00
`define TLB_OFS_TAG 8'h04
`define TLB_OFS_DATA 8'h08
`define TLB_OFS_COMMIT 8'h0C
`define TLB_OFS_STATUS 8'h10

`define TLB_CTRL_EH_BIT 31
`define TLB_TAG_G_BIT 31
`define TLB_DATA_C_BIT 24
`define TLB_DATA_R_BIT 25
`define TLB_DATA_W_BIT 26
`define TLB_DATA_X_BIT 27
`define TLB_STAT_PERM_BIT 24
`define TLB_STAT_FAST_BIT 25
`define TLB_STAT_DBL_BIT 26
`define TLB_STAT_KIND_LSB 28

`define TLB_VPN_W 20
`define TLB_OFF_W 12
`define TLB_BYPASS_TOP 2'h3
`define TLB_KERNEL_PART 3'h6

`define TLB_RST_CTRL 32'h0000_0000
`define TLB_RST_TAG 32'h0000_0000
`define TLB_RST_DATA 32'h0000_0000
`define TLB_RST_STATUS 32'h0000_0000

`endif

// ---- hdl/tlb_pkg.sv ----
// types shared by the translation buffer files
package tlb_pkg;
   // kind of access presented for translation
   typedef enum logic [1:0] {
      ACC_FETCH,
      ACC_LOAD,
      ACC_STORE,
      ACC_FLUSH
   } acc_e;
endpackage

// ---- hdl/tlb_way_ram.sv ----
// set-organised entry ram, one write lane per way, registered read of a whole set
`timescale 1ns/1ps
module tlb_way_ram #(
   parameter int SETS = 8,
   parameter int WAYS = 16,
   parameter int EW = 53,
   parameter int SET_W = 3,
   parameter int WAY_W = 4
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [SET_W-1:0] wset,
   input wire logic [WAY_W-1:0] wway,
   input wire logic [EW-1:0] wdata,
   input wire logic [SET_W-1:0] rset,
   output logic [WAYS*EW-1:0] rdata
);

   genvar w;
   generate
      for (w = 0; w < WAYS; w++)
      begin : g_way
         logic [EW-1:0] mem [SETS];
         // write lane of one way, selected by software
         always_ff @(posedge clk)
         begin
            if (we && (wway == WAY_W'(w)))
            begin
               mem[wset] <= wdata;
            end
         end
         // synchronous read, as a block ram needs
         always_ff @(posedge clk)
         begin
            rdata[w*EW +: EW] <= mem[rset];
         end
      end
   endgenerate

endmodule
